// file: design/anbp_base_page_regs.sv
// Auto-negotiation base page registers: local advertisement and partner base page.
// Function
// - Read/write 16-bit advertisement register at management index 4.
// - Bit 15 next page capability, writable, resets to 0.
// - Bit 13 remote fault advertisement, writable, resets to 0.
// - Bit 11 asymmetric pause advertisement, resets to 1.
// - Bit 10 symmetric pause advertisement, resets to 1.
// - Bits 8..5 advertise 100 full, 100 half, 10 full, 10 half.
// - Bits 8..5 reset to 0 and load from the four mode strapping pins after reset release, unless a write to index 4 lands in the load cycle.
// - Bits 4:0 selector; local one writable, resets to 00001.
// - Read-only 16-bit partner ability register at management index 5.
// - Partner bit 15 reports partner next page capability, 0 after reset.
// - Partner bit 14 reads 1 once a code word was received.
// - Partner bit 13 remote fault, bit 12 extended next page.
// - Partner bits 11 and 10 report asymmetric and symmetric pause.
// - Partner bit 9 reports 100BASE-T4 ability, 0 after reset.
// - Partner bits 8..5 report speed and duplex abilities in order.
// - Page-received flag sets on a new page, holds, clears on read.
`timescale 1ns/100ps
`default_nettype none
module anbp_base_page_regs (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   input  wire logic [3:0]  modeStrap,
   input  wire logic [4:0]  regAddr,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [15:0] regWrData,
   input  wire logic        pageRxValid,
   input  wire logic [15:0] pageRxWord,
   output var  logic [15:0] regRdData,
   output var  logic [15:0] advertWord,
   output var  logic        nextPageAdv,
   output var  logic        remoteFaultAdv,
   output var  logic [1:0]  pauseAdv,
   output var  logic [3:0]  speedDuplexAdv,
   output var  logic [15:0] partnerWord,
   output var  logic        pageReceived
);
   logic [15:0] advert_q;
   logic [15:0] advert_d;
   logic [15:0] partner_q;
   logic        ackSeen_q;
   logic        pageFlag_q;
   logic        pageFlag_d;
   logic        strapsLoaded_q;
   logic [3:0]  strapVal;
   logic        strapValid;
   logic        hitAdvert;
   logic        hitPartner;
   logic        hitExpansion;
   logic        advertWrite;
   logic        expansionRead;
   logic [15:0] partnerView;
   logic [15:0] readMux;

   // Address match used by both the read and the write decoders.
   function automatic logic addrHit(input logic [4:0] a, input logic [4:0] idx);
      addrHit = (a == idx);
   endfunction

   anbp_strap_latch u_strap (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .clkEn      (clkEn),
      .modeStrap  (modeStrap),
      .strapVal   (strapVal),
      .strapValid (strapValid)
   );

   assign hitAdvert     = addrHit(regAddr, anbp_pkg::IDX_ADVERT);
   assign hitPartner    = addrHit(regAddr, anbp_pkg::IDX_PARTNER);
   assign hitExpansion  = addrHit(regAddr, anbp_pkg::IDX_EXPANSION);
   assign advertWrite   = regWrEn && hitAdvert;
   assign expansionRead = regRdEn && hitExpansion;

   // Bit 14 is masked so a write there has no effect and it reads back 0.
   assign advert_d = (regWrData & anbp_pkg::ADV_WRITE_MASK);

   // Partner acknowledge is sticky once any code word arrives.
   assign partnerView = {partner_q[15], ackSeen_q, partner_q[13:0]};

   // A new page wins over a clearing read in the same cycle.
   assign pageFlag_d = pageRxValid ? 1'b1 : (expansionRead ? 1'b0 : pageFlag_q);

   assign readMux = hitAdvert    ? advert_q :
                    hitPartner   ? partnerView :
                    hitExpansion ? (16'h0001 << anbp_pkg::BIT_PAGE_RX) & {16{pageFlag_q}} :
                                   anbp_pkg::ZERO_WORD;

   // Advertisement register. Straps overwrite the speed bits once, right after capture; a write to index 4 in that cycle wins and the straps are dropped.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         advert_q       <= anbp_pkg::ADV_RESET_FIXED;
         strapsLoaded_q <= 1'b0;
      end else if (clkEn) begin
         if (advertWrite) begin
            advert_q <= advert_d;
         end else if (strapValid && !strapsLoaded_q) begin
            advert_q[anbp_pkg::SPEED_LSB +: 4] <= strapVal;
         end
         if (strapValid) begin
            strapsLoaded_q <= 1'b1;
         end
      end
   end

   // Partner register loads only from the line side; management writes are ignored.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         partner_q <= anbp_pkg::PARTNER_RESET;
         ackSeen_q <= 1'b0;
      end else if (clkEn && pageRxValid) begin
         partner_q <= pageRxWord;
         ackSeen_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pageFlag_q <= 1'b0;
      end else if (clkEn) begin
         pageFlag_q <= pageFlag_d;
      end
   end

   // Registered outputs; read data follows the address with one cycle of latency.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         regRdData      <= anbp_pkg::ZERO_WORD;
         advertWord     <= anbp_pkg::ADV_RESET_FIXED;
         nextPageAdv    <= 1'b0;
         remoteFaultAdv <= 1'b0;
         pauseAdv       <= 2'h3;
         speedDuplexAdv <= 4'h0;
         partnerWord    <= anbp_pkg::PARTNER_RESET;
         pageReceived   <= 1'b0;
      end else if (clkEn) begin
         regRdData      <= readMux;
         advertWord     <= advert_q;
         nextPageAdv    <= advert_q[anbp_pkg::BIT_NEXT_PAGE];
         remoteFaultAdv <= advert_q[anbp_pkg::BIT_REMOTE_FAULT];
         pauseAdv       <= advert_q[anbp_pkg::BIT_SYM_PAUSE +: 2];
         speedDuplexAdv <= advert_q[anbp_pkg::SPEED_LSB +: 4];
         partnerWord    <= partnerView;
         pageReceived   <= pageFlag_q;
      end
   end
endmodule // anbp_base_page_regs
`default_nettype wire

// file: design/anbp_strap_latch.sv
// Captures the mode straps once after reset release for the speed/duplex advert defaults.
`timescale 1ns/100ps
`default_nettype none
module anbp_strap_latch (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       clkEn,
   input  wire logic [3:0] modeStrap,
   output var  logic [3:0] strapVal,
   output var  logic       strapValid
);
   // The strap level is caught by a clocked process after release, never by the reset itself.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         strapVal   <= 4'h0;
         strapValid <= 1'b0;
      end else if (clkEn && !strapValid) begin
         strapVal   <= modeStrap;
         strapValid <= 1'b1;
      end
   end
endmodule // anbp_strap_latch
`default_nettype wire

// file: include/anbp_pkg.sv
// Package with register indices, field positions and reset values of the base page registers.
package anbp_pkg;
   localparam logic [4:0]  IDX_ADVERT       = 5'h04;
   localparam logic [4:0]  IDX_PARTNER      = 5'h05;
   localparam logic [4:0]  IDX_EXPANSION    = 5'h06;
   localparam int          BIT_NEXT_PAGE    = 15;
   localparam int          BIT_ACK          = 14;
   localparam int          BIT_REMOTE_FAULT = 13;
   localparam int          BIT_EXT_NP       = 12;
   localparam int          BIT_ASYM_PAUSE   = 11;
   localparam int          BIT_SYM_PAUSE    = 10;
   localparam int          BIT_T4           = 9;
   localparam int          BIT_PAGE_RX      = 1;
   localparam int          SPEED_LSB        = 5;
   localparam int          SEL_LSB          = 0;
   // Writable mask of the advertisement register; the reserved bit 14 is held at zero.
   localparam logic [15:0] ADV_WRITE_MASK   = 16'hbfff;
   localparam logic [15:0] ADV_RESET_FIXED  = 16'h0c01;
   localparam logic [4:0]  SELECTOR_8023    = 5'h01;
   localparam logic [15:0] PARTNER_RESET    = 16'h0000;
   localparam logic [15:0] ZERO_WORD        = 16'h0000;
endpackage

// file: verification/anbp_base_page_regs_sva.sv
// Checker of the base page register bank.
`timescale 1ns/100ps
`default_nettype none
module anbp_base_page_regs_sva (
   input wire logic        clk_sys, rst_b, clkEn, regWrEn, regRdEn, pageRxValid,
   input wire logic [4:0]  regAddr,
   input wire logic [15:0] regWrData, pageRxWord, regRdData, advertWord, partnerWord,
   input wire logic        nextPageAdv, remoteFaultAdv, pageReceived,
   input wire logic [1:0]  pauseAdv,
   input wire logic [3:0]  speedDuplexAdv
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence pg;
      clkEn && pageRxValid ##1 clkEn;
   endsequence
   a_partner_load:
      assert property (pg |=> partnerWord == ($past(pageRxWord, 2) | 16'h4000)) else $error("bad");
   a_page_flag:
      assert property (pg |=> pageReceived) else $error("flag");
   a_advert_write:
      assert property (clkEn && regWrEn && regAddr == 5'h04 ##1 clkEn
         |=> advertWord == ($past(regWrData, 2) & 16'hbfff)) else $error("adv");
   a_reserved_zero:
      assert property (!advertWord[14]) else $error("bit14");
   a_fields_match:
      assert property ({nextPageAdv, remoteFaultAdv, pauseAdv, speedDuplexAdv} == {advertWord[15],
         advertWord[13], advertWord[11:10], advertWord[8:5]}) else $error("fields");
   a_read_advert:
      assert property (clkEn && regAddr == 5'h04 |=> regRdData == advertWord) else $error("rd4");
   a_read_partner:
      assert property (clkEn && regAddr == 5'h05 |=> regRdData == partnerWord) else $error("rd5");
   a_freeze_state:
      assert property (!clkEn |=> $stable(advertWord) && $stable(partnerWord)) else $error("en");
   cover property (pg);
   cover property (clkEn && regWrEn && regAddr == 5'h04);
   cover property (clkEn && regRdEn && regAddr == 5'h06 && pageReceived);
endmodule // anbp_base_page_regs_sva
bind anbp_base_page_regs anbp_base_page_regs_sva u_anbp_base_page_regs_sva (.*);
`default_nettype wire

// file: verification/anbp_link_partner.sv
// Model of the remote link partner handing base page code words to the block.
`timescale 1ns/100ps
`default_nettype none
module anbp_link_partner (
   input  wire logic        clk_sys,
   output var  logic        pageRxValid,
   output var  logic [15:0] pageRxWord
);
   initial begin
      pageRxValid = 1'b0;
      pageRxWord = 16'h0000;
   end
   // Idle word lines carry the inverse of the last page, so a load without the strobe shows.
   task automatic send(input logic [15:0] w);
      @(negedge clk_sys);
      pageRxValid = 1'b1;
      pageRxWord = w;
      @(negedge clk_sys);
      pageRxValid = 1'b0;
      pageRxWord = ~w;
   endtask
endmodule // anbp_link_partner
`default_nettype wire

// file: verification/tb.sv
// Testbench of the base page register bank.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic             clk_sys, rst_b, clkEn, regWrEn, regRdEn;
   logic [3:0]       modeStrap;
   logic [4:0]       regAddr;
   logic [15:0]      regWrData;
   wire logic        pageRxValid, nextPageAdv, remoteFaultAdv, pageReceived;
   wire logic [15:0] pageRxWord, regRdData, advertWord, partnerWord;
   wire logic [1:0]  pauseAdv;
   wire logic [3:0]  speedDuplexAdv;
   int               err_count, n_tests;
   logic [31:0]      rows [4] = '{32'hedff_adff, 32'h0000_0000, 32'h4c01_0c01, 32'ha120_a120};
   anbp_base_page_regs u_anbp_base_page_regs (.*);
   anbp_link_partner u_anbp_link_partner (.*);
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %0t: got %h, expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(negedge clk_sys);
      regAddr = a;
      regWrData = v;
      regWrEn = 1'b1;
      @(negedge clk_sys);
      regWrEn = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(negedge clk_sys);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk_sys);
      regRdEn = 1'b0;
      chk(regRdData, e);
   endtask
   task automatic stop_test;
      if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #100000;
      err_count++;
      stop_test;
   end
   initial begin
      {rst_b, regWrEn, regRdEn, regAddr, regWrData} = '0;
      clkEn = 1'b1;
      modeStrap = 4'ha;
      repeat (4) @(negedge clk_sys);
      chk(advertWord, 16'h0c01);
      chk(partnerWord, 16'h0000);
      rst_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      rd(5'h04, 16'h0d41);
      for (int i = 0; i < 4; i++) begin
         wr(5'h04, rows[i][31:16]);
         rd(5'h04, rows[i][15:0]);
         chk(advertWord, rows[i][15:0]);
         chk({8'h00, nextPageAdv, remoteFaultAdv, pauseAdv, speedDuplexAdv}, {8'h00, rows[i][15], rows[i][13], rows[i][11:10], rows[i][8:5]});
      end
      wr(5'h05, 16'hffff);
      rd(5'h05, 16'h0000);
      rd(5'h1f, 16'h0000);
      u_anbp_link_partner.send(16'h8de1);
      rd(5'h05, 16'hcde1);
      u_anbp_link_partner.send(16'h3fe1);
      rd(5'h05, 16'h7fe1);
      chk(partnerWord, 16'h7fe1);
      chk({15'h0000, pageReceived}, 16'h0001);
      rd(5'h06, 16'h0002);
      rd(5'h06, 16'h0000);
      clkEn = 1'b0;
      wr(5'h04, 16'h0000);
      clkEn = 1'b1;
      rd(5'h04, 16'ha120);
      modeStrap = 4'h5;
      rst_b = 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      rd(5'h05, 16'h0000);
      rd(5'h04, 16'h0ca1);
      stop_test;
   end
endmodule // tb
`default_nettype wire
